//--- common/adc_ctrl_pkg.sv
// Package: register map, field layout, codes and timing for the converter control block
package adc_ctrl_pkg;

  // Register byte addresses (word aligned)
  localparam logic [11:0] control_addr     = 12'h000;
  localparam logic [11:0] config_addr      = 12'h004;
  localparam logic [11:0] trigger_addr     = 12'h008;
  localparam logic [11:0] result_high_addr = 12'h00c;
  localparam logic [11:0] result_low_addr  = 12'h010;
  localparam logic [11:0] status_addr      = 12'h014;

  // Control register fields
  localparam int enable_bit   = 0;
  localparam int go_bit       = 1;
  localparam int chan_lsb     = 2;
  localparam int chan_w       = 6;

  // Config register fields
  localparam int pref_lsb     = 0;
  localparam int nref_bit     = 2;
  localparam int cs_lsb       = 4;
  localparam int justify_bit  = 7;
  localparam logic [7:0] config_mask  = 8'hf7;
  localparam logic [7:0] trigger_mask = 8'h1f;
  localparam logic [7:0] reg_reset    = 8'h00;

  // Status register fields
  localparam int irq_flag_bit = 0;
  localparam int busy_bit     = 1;

  // Conversion clock select codes
  typedef enum logic [2:0] {
    cs_div2  = 3'b000,
    cs_div8  = 3'b001,
    cs_div32 = 3'b010,
    cs_rc_a  = 3'b011,
    cs_div4  = 3'b100,
    cs_div16 = 3'b101,
    cs_div64 = 3'b110,
    cs_rc_b  = 3'b111
  } conv_clock_select_t;

  // Positive reference codes
  typedef enum logic [1:0] {
    pref_supply   = 2'b00,
    pref_reserved = 2'b01,
    pref_pin      = 2'b10,
    pref_fixed    = 2'b11
  } pos_ref_select_t;

  // Reference routing towards the analog switches, one enable bit per switch
  typedef struct packed {
    logic pos_supply;
    logic pos_pin;
    logic pos_fixed;
    logic neg_ground;
    logic neg_pin;
  } ref_route_t;

  // Trigger source bundle
  typedef struct packed {
    logic       timer0_ovf_flag;
    logic       timer1_ovf_flag;
    logic       timer2_period_match;
    logic       timer3_ovf_flag;
    logic       timer4_period_match;
    logic       timer5_ovf_flag;
    logic       timer6_period_match;
    logic [1:0] comparator;
    logic [3:0] logic_cell;
    logic [3:0] capture_compare;
  } trigger_sources_t;

  // Converter core handshake and conversion clock divider sizing
  localparam int result_w = 10;
  localparam int ticks_per_conversion = 12;
  localparam int div_w = 6;
  localparam logic [div_w-1:0] div_max = 6'h3f;

endpackage

//--- hw/adc_config_trigger_result.sv
// Converter control: APB registers, references, trigger, conversion sequencing, results
//
// How it works
// - Right justify clears upper six high bits
// - Left justify clears lower six low bits
// - Clock select picks system clock divider
// - Codes 011 and 111 pick RC clock
// - Negative reference: ground or external pin
// - Disabled converter disconnects all multiplexer inputs
// - Positive reference: supply, pin, fixed reference
// - Trigger select zero disables auto trigger
// - Trigger codes map to timer sources
// - Trigger codes map comparators, cells, capture units
// - Selected trigger acts on rising edge
// - Timer overflow trigger is flag setting
// - Left justify result placement
// - Right justify result placement
// - Control bits reset zero; results keep
// - Unimplemented bits read zero, ignore writes
// - Go flag starts, stays, self clears
// - Enable bit powers the converter
// - Channel field routes input; reserved none
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module adc_config_trigger_result
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_TICKS = adc_ctrl_pkg::ticks_per_conversion  // Ticks per conversion
) (
  input  wire logic                           clock,            // 125 MHz system clock
  input  wire logic                           rst,              // Synchronous reset, high
  input  wire logic                           psel,             // APB select
  input  wire logic                           penable,          // APB access phase
  input  wire logic                           pwrite,           // APB write
  input  wire logic [11:0]                    paddr,            // APB byte address
  input  wire logic [31:0]                    pwdata,           // APB write data
  output logic                                pready,           // APB ready
  output logic [31:0]                         prdata,           // APB read data
  output logic                                pslverr,          // APB error
  input  wire adc_ctrl_pkg::trigger_sources_t trig_sources,     // Auto trigger sources
  input  wire logic                           rc_tick,          // RC oscillator tick
  input  wire logic [9:0]                     core_result,      // Analog core result bits
  output logic                                converter_enable, // Converter powered
  output adc_ctrl_pkg::ref_route_t            ref_route,        // Reference switch enables
  output logic [5:0]                          channel_select,   // Channel routed to core
  output logic                                channel_connect,  // Channel switch closed
  output logic                                sample_hold,      // Core converting
  output logic                                conv_tick,        // Conversion clock enable
  output logic                                dedicated_rc_clock, // RC clock in use
  output logic                                converter_irq_flag  // Conversion done flag
);
  import adc_ctrl_pkg::*;

  // The tick countdown is eight bits wide, so longer conversions cannot be counted
  if (CONV_TICKS < 1 || CONV_TICKS > 255) begin : g_ticks_check
    $error("CONV_TICKS out of range");
  end

  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_conv = 1'b1
  } conv_state_t;

  conv_state_t      state;
  logic [7:0]       control;
  logic [7:0]       converter_config;
  logic [7:0]       auto_trigger_source;
  logic [7:0]       result_high;
  logic [7:0]       result_low;
  logic [7:0]       ticks_left;
  logic             go;
  logic             irq_flag;
  logic             trig_fire;
  logic             tick;

  // APB decode
  wire access   = psel && penable;
  wire wr       = access && pwrite;
  wire hit_ctl  = (paddr == control_addr);
  wire hit_cfg  = (paddr == config_addr);
  wire hit_trg  = (paddr == trigger_addr);
  wire hit_rh   = (paddr == result_high_addr);
  wire hit_rl   = (paddr == result_low_addr);
  wire hit_st   = (paddr == status_addr);
  wire mapped   = hit_ctl || hit_cfg || hit_trg || hit_rh || hit_rl || hit_st;

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // Field views
  wire        enabled     = control[enable_bit];
  wire        justify     = converter_config[justify_bit];
  wire [2:0]  cs_code     = converter_config[cs_lsb +: 3];
  wire [1:0]  pref_code   = converter_config[pref_lsb +: 2];
  wire        nref        = converter_config[nref_bit];
  wire [5:0]  chan        = control[chan_lsb +: chan_w];

  // Channel codes with nothing behind them
  wire chan_reserved = (chan == 6'h03) || (chan >= 6'h06 && chan <= 6'h0b) ||
                       (chan >= 6'h18 && chan <= 6'h3b);

  // Start requests from software or trigger, ignored while busy or disabled
  wire sw_start  = wr && hit_ctl && pwdata[go_bit] && pwdata[enable_bit];
  wire hw_start  = trig_fire && enabled;
  wire start     = (state == st_idle) && (sw_start || hw_start);
  wire finish    = (state == st_conv) && tick && (ticks_left == 8'h01);

  // Justified result images
  wire [7:0] next_high = justify ? {6'h00, core_result[9:8]}
                                 : core_result[9:2];
  wire [7:0] next_low  = justify ? core_result[7:0]
                                 : {core_result[1:0], 6'h00};

  trigger_select u_trigger (
    .clock   (clock),
    .rst     (rst),
    .sources (trig_sources),
    .select  (auto_trigger_source[4:0]),
    .fire    (trig_fire)
  );

  conv_clock_gen u_clock (
    .clock    (clock),
    .rst      (rst),
    .run      (state == st_conv),
    .select   (conv_clock_select_t'(cs_code)),
    .rc_tick  (rc_tick),
    .tick     (tick),
    .using_rc (dedicated_rc_clock)
  );

  // Configuration registers
  always_ff @(posedge clock) begin
    if (rst) begin
      control             <= reg_reset;
      converter_config    <= reg_reset;
      auto_trigger_source <= reg_reset;
    end else begin
      if (wr && hit_ctl) begin
        control <= {pwdata[7:2], 1'b0, pwdata[0]};
      end
      if (wr && hit_cfg) begin
        converter_config <= pwdata[7:0] & config_mask;
      end
      if (wr && hit_trg) begin
        auto_trigger_source <= pwdata[7:0] & trigger_mask;
      end
    end
  end

  // Conversion sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state      <= st_idle;
      go         <= 1'b0;
      ticks_left <= 8'h00;
    end else begin
      unique case (state)
        st_idle: begin
          if (start) begin
            state      <= st_conv;
            go         <= 1'b1;
            ticks_left <= CONV_TICKS[7:0];
          end
        end
        st_conv: begin
          if (!enabled) begin
            state <= st_idle;
            go    <= 1'b0;
          end else if (finish) begin
            state <= st_idle;
            go    <= 1'b0;
          end else if (tick) begin
            ticks_left <= ticks_left - 8'h01;
          end
        end
      endcase
    end
  end

  // Results are not reset: they keep their contents across resets
  always_ff @(posedge clock) begin
    if (finish && enabled) begin
      result_high <= next_high;
      result_low  <= next_low;
    end else begin
      if (wr && hit_rh) begin
        result_high <= pwdata[7:0];
      end
      if (wr && hit_rl) begin
        result_low <= pwdata[7:0];
      end
    end
  end

  // Done flag; a completion in the clearing cycle wins
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_flag <= 1'b0;
    end else if (finish && enabled) begin
      irq_flag <= 1'b1;
    end else if (wr && hit_st && pwdata[irq_flag_bit]) begin
      irq_flag <= 1'b0;
    end
  end

  // Read mux
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctl) rd_byte = {control[7:2], go, control[0]};
    if (hit_cfg) rd_byte = converter_config;
    if (hit_trg) rd_byte = auto_trigger_source;
    if (hit_rh)  rd_byte = result_high;
    if (hit_rl)  rd_byte = result_low;
    if (hit_st)  rd_byte = {6'h00, go, irq_flag};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // Analog routing, all open while disabled
  assign converter_enable   = enabled;
  assign ref_route.pos_supply = enabled && (pref_code == pref_supply);
  assign ref_route.pos_pin    = enabled && (pref_code == pref_pin);
  assign ref_route.pos_fixed  = enabled && (pref_code == pref_fixed);
  assign ref_route.neg_ground = enabled && !nref;
  assign ref_route.neg_pin    = enabled && nref;
  assign channel_select     = chan;
  assign channel_connect    = enabled && !chan_reserved;
  assign sample_hold        = (state == st_conv);
  assign conv_tick          = tick;
  assign converter_irq_flag = irq_flag;

endmodule

//--- hw/conv_clock_gen.sv
// Conversion clock tick generator: system clock dividers or the RC clock
`timescale 1ns/1ps
module conv_clock_gen
  import adc_ctrl_pkg::*;
(
  input  wire logic                             clock,     // System clock
  input  wire logic                             rst,       // Synchronous reset
  input  wire logic                             run,       // Divider runs while high
  input  wire adc_ctrl_pkg::conv_clock_select_t select,    // Clock select code
  input  wire logic                             rc_tick,   // RC oscillator tick, synchronous
  output logic                                  tick,      // One-cycle conversion clock enable
  output logic                                  using_rc   // RC clock selected
);
  import adc_ctrl_pkg::*;

  logic [div_w-1:0] count;
  logic [div_w-1:0] limit;

  always_comb begin
    unique case (select)
      cs_div2:  limit = 6'h01;
      cs_div4:  limit = 6'h03;
      cs_div8:  limit = 6'h07;
      cs_div16: limit = 6'h0f;
      cs_div32: limit = 6'h1f;
      cs_div64: limit = div_max;
      default:  limit = 6'h00;
    endcase
  end

  assign using_rc = (select == cs_rc_a) || (select == cs_rc_b);
  wire   div_tick = run && (count == limit);

  always_ff @(posedge clock) begin
    if (rst || !run || div_tick) begin
      count <= '0;
    end else begin
      count <= count + 6'h01;
    end
  end

  assign tick = using_rc ? (run && rc_tick) : div_tick;

endmodule

//--- hw/trigger_select.sv
// Auto-conversion trigger multiplexer with rising edge detection
`timescale 1ns/1ps
module trigger_select
  import adc_ctrl_pkg::*;
(
  input  wire logic                           clock,    // System clock
  input  wire logic                           rst,      // Synchronous reset
  input  wire adc_ctrl_pkg::trigger_sources_t sources,  // Peripheral event levels
  input  wire logic [4:0]                     select,   // Trigger source code
  output logic                                fire      // One-cycle trigger pulse
);
  import adc_ctrl_pkg::*;

  logic chosen;
  logic chosen_q;
  wire  sel_zero = (select == 5'h00);

  always_comb begin
    unique case (select)
      5'h01:   chosen = sources.timer4_period_match;
      5'h02:   chosen = sources.timer6_period_match;
      5'h03:   chosen = sources.timer0_ovf_flag;
      5'h04:   chosen = sources.timer1_ovf_flag;
      5'h05:   chosen = sources.timer2_period_match;
      5'h06:   chosen = sources.comparator[0];
      5'h07:   chosen = sources.comparator[1];
      5'h08:   chosen = sources.logic_cell[0];
      5'h09:   chosen = sources.logic_cell[1];
      5'h0a:   chosen = sources.logic_cell[2];
      5'h0b:   chosen = sources.logic_cell[3];
      5'h0c:   chosen = sources.capture_compare[0];
      5'h0d:   chosen = sources.capture_compare[1];
      5'h0e:   chosen = sources.capture_compare[2];
      5'h0f:   chosen = sources.capture_compare[3];
      5'h10:   chosen = sources.timer3_ovf_flag;
      5'h11:   chosen = sources.timer5_ovf_flag;
      default: chosen = 1'b0;
    endcase
  end

  // Changing the select may show a false edge; the history is kept after the multiplexer, not per source
  always_ff @(posedge clock) begin
    if (rst) begin
      chosen_q <= 1'b0;
    end else begin
      chosen_q <= chosen;
    end
  end

  assign fire = !sel_zero && chosen && !chosen_q;

endmodule

//--- tb/adc_ctrl_checker.sv
// Concurrent checks on the converter control block ports
`timescale 1ns/1ps
module adc_ctrl_checker
  import adc_ctrl_pkg::*;
(
  input wire logic                     clock,              // System clock
  input wire logic                     rst,                // Synchronous reset
  input wire logic                     psel,               // APB select
  input wire logic                     penable,            // APB access phase
  input wire logic                     pwrite,             // APB write
  input wire logic [11:0]              paddr,              // APB address
  input wire logic [31:0]              pwdata,             // APB write data
  input wire logic                     converter_enable,   // Converter powered
  input wire adc_ctrl_pkg::ref_route_t ref_route,          // Reference switches
  input wire logic [5:0]               channel_select,     // Routed channel
  input wire logic                     channel_connect,    // Channel switch closed
  input wire logic                     sample_hold,        // Converting
  input wire logic                     conv_tick,          // Conversion clock enable
  input wire logic                     dedicated_rc_clock, // RC clock in use
  input wire logic                     converter_irq_flag  // Conversion done flag
);
  import adc_ctrl_pkg::*;

  logic [7:0] cfg;

  // Shadow of the config register, updated on the same edge as the real one
  always_ff @(posedge clock) begin
    if (rst)
      cfg <= 8'h00;
    else if (psel && penable && pwrite && paddr == config_addr)
      cfg <= pwdata[7:0];
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_rc_select: assert property (dedicated_rc_clock == (cfg[5:4] == 2'b11))
    else $error("RC clock flag does not follow clock select");
  a_off_isolated: assert property (!converter_enable |-> ref_route == '0 && !channel_connect)
    else $error("Switches closed while converter disabled");
  a_pos_route: assert property (converter_enable |->
    ref_route.pos_supply == (cfg[1:0] == 2'b00) && ref_route.pos_pin == (cfg[1:0] == 2'b10)
    && ref_route.pos_fixed == (cfg[1:0] == 2'b11))
    else $error("Positive reference route wrong");
  a_neg_route: assert property (converter_enable |->
    ref_route.neg_pin == cfg[2] && ref_route.neg_ground == !cfg[2])
    else $error("Negative reference route wrong");
  a_tick_busy: assert property (conv_tick |-> sample_hold)
    else $error("Conversion tick outside conversion");
  a_div2_gap: assert property (conv_tick && cfg[6:4] == 3'b000 |=> !conv_tick)
    else $error("Divide-by-two ticks too close");
  a_done_flag: assert property ($fell(sample_hold) && converter_enable |-> converter_irq_flag)
    else $error("Conversion ended without done flag");
  a_reserved_chan: assert property (converter_enable |-> channel_connect ==
    !(channel_select == 6'h03 || (channel_select >= 6'h06 && channel_select <= 6'h0b)
    || (channel_select >= 6'h18 && channel_select <= 6'h3b)))
    else $error("Channel switch wrong for channel code");
endmodule

bind adc_config_trigger_result adc_ctrl_checker i_adc_ctrl_checker (
  .clock              (clock),
  .rst                (rst),
  .psel               (psel),
  .penable            (penable),
  .pwrite             (pwrite),
  .paddr              (paddr),
  .pwdata             (pwdata),
  .converter_enable   (converter_enable),
  .ref_route          (ref_route),
  .channel_select     (channel_select),
  .channel_connect    (channel_connect),
  .sample_hold        (sample_hold),
  .conv_tick          (conv_tick),
  .dedicated_rc_clock (dedicated_rc_clock),
  .converter_irq_flag (converter_irq_flag)
);

//--- tb/adc_far_side.sv
// Far-side model: peripheral event lines, RC oscillator ticks, analog core result
`timescale 1ns/1ps
module adc_far_side
  import adc_ctrl_pkg::*;
#(
  parameter int RC_DIV = 5  // System clocks per RC oscillator period
) (
  input  wire logic                      clock,        // System clock
  input  wire logic                      rst,          // Synchronous reset
  input  wire logic [16:0]               events,       // Event levels, struct order
  input  wire logic [9:0]                result_in,    // Value the core converts
  input  wire logic                      busy,         // Core converting
  output adc_ctrl_pkg::trigger_sources_t trig_sources, // Event lines to the block
  output logic                           rc_tick,      // RC oscillator tick
  output logic [9:0]                     core_result   // Core result bits
);
  import adc_ctrl_pkg::*;

  logic [3:0] rc_count;

  // Timer overflow lines carry the timers' interrupt flags, so they rise as a flag sets
  assign trig_sources = events;
  // Result lines are not valid outside a conversion: show a misleading value there
  assign core_result = busy ? result_in : ~result_in;
  assign rc_tick = (rc_count == 4'h0);

  always_ff @(posedge clock) begin
    if (rst || rc_count == 4'(RC_DIV - 1))
      rc_count <= 4'h0;
    else
      rc_count <= rc_count + 4'h1;
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module testbench;
  import adc_ctrl_pkg::*;
  localparam int TICKS = 2;
  localparam int RC_DIV = 5;
  localparam int src_idx [18] = '{0, 12, 10, 16, 15, 14, 8, 9, 4, 5, 6, 7, 0, 1, 2, 3, 13, 11};
  localparam int div_of [8] = '{2, 8, 32, RC_DIV, 4, 16, 64, RC_DIV};
  localparam logic [5:0] chan_tab [4] = '{6'h03, 6'h05, 6'h3b, 6'h3c};
  logic             clock = 1'b0;
  logic             rst = 1'b1;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0;
  logic [16:0]      events = 17'h0;
  logic [9:0]       result_in = 10'h2d6;
  logic             pready, pslverr, converter_enable, channel_connect, sample_hold;
  logic             conv_tick, dedicated_rc_clock, converter_irq_flag, rc_tick, err;
  logic [31:0]      prdata, rd;
  logic [5:0]       channel_select;
  logic [9:0]       core_result;
  ref_route_t       ref_route;
  trigger_sources_t trig_sources;
  int               err_count = 0;
  int               n_tests = 0;
  int               cyc;

  always #4 clock = ~clock;

  adc_config_trigger_result #(.CONV_TICKS(TICKS)) i_adc_config_trigger_result (.*);
  adc_far_side #(.RC_DIV(RC_DIV)) i_adc_far_side (.*, .busy(sample_hold));

  task automatic finish_test();
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Setup cycle, then access until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("[FAIL] %0t no ready", $time);
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, exp)
  endtask

  // Flag is looked at on the falling edge, where it has settled; the count is
  // one more than the edges from start to completion. Returns on a rising edge.
  task automatic wait_irq(output int c);
    c = 0;
    while (converter_irq_flag !== 1'b1) begin
      @(negedge clock);
      c++;
      if (c > 400) begin
        err_count++;
        $display("[FAIL] %0t conversion never ended", $time);
        finish_test();
      end
    end
    @(posedge clock);
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rchk(config_addr, 32'h0);
    rchk(trigger_addr, 32'h0);
    xfer(1'b1, config_addr, 32'hff);
    rchk(config_addr, 32'hf7);
    xfer(1'b1, trigger_addr, 32'hff);
    rchk(trigger_addr, 32'h1f);
    xfer(1'b0, 12'h020, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    xfer(1'b1, trigger_addr, 32'h0);
    @(negedge clock);
    `CHK(ref_route, 5'h00)
    xfer(1'b1, control_addr, 32'h01);
    @(negedge clock);
    `CHK(converter_enable, 1'b1)
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, config_addr, 32'(i));
      @(negedge clock);
      `CHK(ref_route, {i[1:0] == 2'b00, i[1:0] == 2'b10, i[1:0] == 2'b11, !i[2], i[2]})
    end
    foreach (chan_tab[k]) begin
      xfer(1'b1, control_addr, {24'h0, chan_tab[k], 2'b01});
      @(negedge clock);
      `CHK({channel_select, channel_connect}, {chan_tab[k], k[0]})
    end
    for (int s = 0; s < 8; s++) begin
      xfer(1'b1, config_addr, {25'h0, 3'(s), 4'h0});
      @(negedge clock);
      `CHK(dedicated_rc_clock, s[1:0] == 2'b11)
      xfer(1'b1, control_addr, 32'h03);
      wait_irq(cyc);
      `CHK(cyc - 1 <= TICKS * div_of[s] && cyc - 1 > TICKS * div_of[s] - (s[1:0] == 2'b11 ? RC_DIV : 1), 1'b1)
      xfer(1'b1, status_addr, 32'h1);
    end
    for (int j = 0; j < 2; j++) begin
      xfer(1'b1, config_addr, {24'h0, j[0], 7'h0});
      xfer(1'b1, result_high_addr, 32'hff);
      xfer(1'b1, result_low_addr, 32'hff);
      xfer(1'b1, control_addr, 32'h03);
      rchk(control_addr, 32'h03);
      wait_irq(cyc);
      rchk(control_addr, 32'h01);
      rchk(result_high_addr, j ? {30'h0, result_in[9:8]} : {24'h0, result_in[9:2]});
      rchk(result_low_addr, j ? {24'h0, result_in[7:0]} : {24'h0, result_in[1:0], 6'h0});
      rchk(status_addr, 32'h1);
      xfer(1'b1, status_addr, 32'h1);
      rchk(status_addr, 32'h0);
    end
    xfer(1'b1, config_addr, 32'h60);
    xfer(1'b1, control_addr, 32'h03);
    xfer(1'b1, control_addr, 32'h00);
    @(negedge clock);
    `CHK(converter_enable, 1'b0)
    rchk(status_addr, 32'h0);
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rchk(result_low_addr, {24'h0, result_in[7:0]});
    rchk(config_addr, 32'h0);
    xfer(1'b1, control_addr, 32'h01);
    for (int c = 0; c < 18; c++) begin
      xfer(1'b1, trigger_addr, 32'(c));
      events <= (c == 0) ? 17'h1ffff : 17'h1 << src_idx[c % 17 + 1];
      repeat (3) @(posedge clock);
      events <= 17'h0;
      rchk(status_addr, 32'h0);
      if (c > 0) begin
        events <= 17'h1 << src_idx[c];
        wait_irq(cyc);
        events <= 17'h0;
        rchk(status_addr, 32'h1);
        xfer(1'b1, status_addr, 32'h1);
      end
    end
    finish_test();
  end
endmodule
